//--- pkg/acc_pkg.sv
`default_nettype none
package acc_pkg;
  // Register indices on the plain register port.
  localparam int unsigned ADDR_W = 2;
  localparam logic [1:0] STATUS_CONTROL_REG = 2'h0;
  localparam logic [1:0] RESULT_HIGH_REG    = 2'h1;
  localparam logic [1:0] RESULT_LOW_REG     = 2'h2;
  localparam logic [1:0] CLOCK_CONFIG_REG   = 2'h3;

  // Status and control register fields.
  localparam int unsigned SC_COMPLETE_BIT   = 7;
  localparam int unsigned SC_IRQ_EN_BIT     = 6;
  localparam int unsigned SC_CONTINUOUS_BIT = 5;
  localparam int unsigned CHANNEL_W         = 5;
  localparam logic [4:0]  CHANNEL_OFF       = 5'h1f;

  // Clock configuration register fields.
  localparam int unsigned CC_LOW_POWER_BIT  = 7;
  localparam int unsigned CC_DIV_HI         = 6;
  localparam int unsigned CC_DIV_LO         = 5;
  localparam int unsigned CC_LONG_SAMPLE_BIT = 4;
  localparam int unsigned CC_MODE_HI        = 3;
  localparam int unsigned CC_MODE_LO        = 2;
  localparam int unsigned CC_ASYNC_BIT      = 1;
  localparam int unsigned CC_BUS_CLK_BIT    = 0;

  // Conversion resolution codes and widths.
  localparam logic [1:0]  MODE_8BIT  = 2'h0;
  localparam logic [1:0]  MODE_10BIT = 2'h1;
  localparam int unsigned RESULT_W   = 10;
  localparam int unsigned SAR_W      = RESULT_W + 1;

  // Sample window lengths in converter clock ticks.
  localparam logic [4:0] SAMPLE_SHORT_TICKS = 5'h04;
  localparam logic [4:0] SAMPLE_LONG_TICKS  = 5'h18;

  // Reset values.
  localparam logic [7:0] CHANNEL_RESET  = 8'h1f;
  localparam logic [7:0] CLK_CFG_RESET  = 8'h00;

  typedef enum logic [1:0] {
    ACC_IDLE     = 2'b00,
    ACC_SAMPLE   = 2'b01,
    ACC_CONVERT  = 2'b11,
    ACC_TRANSFER = 2'b10
  } acc_state_t;
endpackage : acc_pkg
`default_nettype wire

//--- verilog/acc_top.sv
// Function
// - Convert selected input by 10-bit successive approximation.
// - Round result to nearest, not truncate.
// - Right-justified result; 8-bit into low only.
// - Set complete flag; interrupt only if enabled.
// - Converter clock: one of three sources, divided.
// - Source from async and input clock selects.
// - Async clock on only while converting, selected.
// - Async clock keeps running in stop mode.
// - Low-power bit picks slower async clock range.
// - Alternate clock is oscillator output clock.
// - Divide selected clock by 1, 2, 4, 8.
// - Exactly one channel connected, from channel select.
// - Resolution 10 or 8 bits from mode.
// - Control write starts conversion unless channel off.
// - No hardware trigger; software writes only.
// - Continuous mode restarts after each transfer.
// - Single mode powers converter down when done.
// - Low power, long sample, continuous supported.
// - Keep converting in wait; in stop only with async clock.
// - Control write aborts conversion in progress.
//
// Local design decisions: the register addresses and the plain strobed port.
`default_nettype none
module acc_top
  import acc_pkg::*;
#(
  parameter int unsigned SAR_BITS = acc_pkg::SAR_W
) (
  // Clock and reset
  input  wire logic                          I_SYS_CLK,
  input  wire logic                          I_RST_N,
  // Register port
  input  wire logic [acc_pkg::ADDR_W-1:0]    I_ADDR,
  input  wire logic [7:0]                    I_WDATA,
  input  wire logic                          I_WR,
  input  wire logic                          I_RD,
  output logic      [7:0]                    O_RDATA,
  output logic                               O_IRQ,
  // Clock sources and power modes
  input  wire logic                          I_ASYNC_CLK,
  input  wire logic                          I_OSC_OUT_CLK,
  input  wire logic                          I_STOP,
  output logic                               O_ASYNC_CLK_EN,
  output logic                               O_LOW_POWER,
  // Analog front end
  input  wire logic                          I_CMP_HIGH,
  output logic      [acc_pkg::CHANNEL_W-1:0] O_CHANNEL,
  output logic                               O_CHANNEL_EN,
  output logic                               O_SAMPLE,
  output logic                               O_CONV_POWER,
  output logic      [acc_pkg::SAR_W-1:0]     O_DAC_CODE
);
  import acc_pkg::*;

  // The rounding taps and the four-bit bit index serve exactly one guard
  // bit below a ten-bit result; other widths would need new taps.
  if (SAR_BITS != SAR_W) begin : g_bad_sar_bits
    $error("acc_top: SAR_BITS must equal one more than result width");
  end
  if (RESULT_W != 10) begin : g_bad_result_w
    $error("acc_top: the rounding taps serve a ten-bit result only");
  end
  // The status byte packs three flag bits above the channel field.
  if (CHANNEL_W != 5) begin : g_bad_channel_w
    $error("acc_top: the channel field must be five bits wide");
  end
  // A zero-length window would wrap the sample counter into a 32-tick window.
  if (SAMPLE_SHORT_TICKS == 5'h00 ||
      SAMPLE_LONG_TICKS == 5'h00) begin : g_bad_sample_len
    $error("acc_top: a sample window needs at least one tick");
  end

  acc_state_t                 state_r;
  acc_state_t                 state_nxt;
  logic [CHANNEL_W-1:0]       channel_r;
  logic                       irq_en_r;
  logic                       continuous_r;
  logic                       complete_r;
  logic                       low_power_r;
  logic [1:0]                 div_sel_r;
  logic                       long_sample_r;
  logic [1:0]                 mode_r;
  logic                       async_sel_r;
  logic                       bus_clk_sel_r;
  logic [1:0]                 result_high_r;
  logic [7:0]                 result_low_r;
  logic [SAR_W-1:0]           trial_r;
  logic [SAR_W-1:0]           trial_nxt;
  logic [3:0]                 bit_r;
  logic [4:0]                 sample_cnt_r;
  logic [2:0]                 div_cnt_r;
  logic                       async_prev_r;
  logic                       osc_prev_r;
  logic                       src_edge;
  logic                       tick;
  logic [2:0]                 div_mask;
  logic                       wr_sc;
  logic                       wr_cc;
  logic                       start;
  logic                       abort;
  logic                       transfer;
  logic [4:0]                 sample_len;
  logic [SAR_W:0]             round10;
  logic [SAR_W:0]             round8;
  logic [RESULT_W-1:0]        res10;
  logic [7:0]                 res8;

  assign wr_sc = I_WR && (I_ADDR == STATUS_CONTROL_REG);
  assign wr_cc = I_WR && (I_ADDR == CLOCK_CONFIG_REG);
  // Only a register write can start a conversion.
  assign start = wr_sc && (I_WDATA[CHANNEL_W-1:0] != CHANNEL_OFF);
  // Stop without the async clock loses the converter clock, so abort.
  // Any control write aborts; the start term then restarts.
  assign abort = wr_sc || wr_cc || (I_STOP && !async_sel_r);
  assign transfer = (state_r == ACC_TRANSFER);

  // Source edge select: async, alternate (oscillator output) or bus.
  // The async and alternate sources are sampled as data on the bus clock, so each must stay
  // below half the bus frequency or some of its edges are lost.
  always_comb begin
    if (async_sel_r) begin
      src_edge = I_ASYNC_CLK && !async_prev_r;
    end else if (bus_clk_sel_r) begin
      src_edge = 1'b1;
    end else begin
      src_edge = I_OSC_OUT_CLK && !osc_prev_r;
    end
  end

  // Divide ratio codes 00..11 give 1, 2, 4, 8.
  always_comb begin
    unique case (div_sel_r)
      2'b00: div_mask = 3'h0;
      2'b01: div_mask = 3'h1;
      2'b10: div_mask = 3'h3;
      2'b11: div_mask = 3'h7;
    endcase
  end
  assign tick = src_edge && ((div_cnt_r & div_mask) == div_mask);

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      async_prev_r <= 1'b0;
      osc_prev_r   <= 1'b0;
    end else begin
      async_prev_r <= I_ASYNC_CLK;
      osc_prev_r   <= I_OSC_OUT_CLK;
    end
  end

  // The divider restarts with every conversion started from idle or by a write,
  // so the first tick of such a sample window takes the full divided period.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_cnt_r <= 3'h0;
    end else if (abort || state_r == ACC_IDLE) begin
      div_cnt_r <= 3'h0;
    end else if (src_edge) begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  assign sample_len = long_sample_r ? SAMPLE_LONG_TICKS
                                    : SAMPLE_SHORT_TICKS;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ACC_IDLE: begin
        state_nxt = ACC_IDLE;
      end
      ACC_SAMPLE: begin
        if (tick && sample_cnt_r == 5'h01) begin
          state_nxt = ACC_CONVERT;
        end
      end
      ACC_CONVERT: begin
        if (tick && bit_r == 4'h0) begin
          state_nxt = ACC_TRANSFER;
        end
      end
      ACC_TRANSFER: begin
        // Continuous mode loops back, single mode powers down.
        state_nxt = continuous_r ? ACC_SAMPLE : ACC_IDLE;
      end
    endcase
    // Abort is applied last so that it overrides every state, and a
    // restarting write still lands in the sample state.
    if (abort) begin
      state_nxt = start ? ACC_SAMPLE : ACC_IDLE;
    end
  end

  // Wait mode has no input at all, and stop only matters through abort,
  // so conversions run on through wait, and through stop with the async clock.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= ACC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The window is loaded on entry to sampling and again when a write
  // restarts a conversion that is already sampling.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sample_cnt_r <= 5'h00;
    end else if (state_nxt == ACC_SAMPLE && state_r != ACC_SAMPLE) begin
      sample_cnt_r <= sample_len;
    end else if (abort && start) begin
      sample_cnt_r <= sample_len;
    end else if (tick && state_r == ACC_SAMPLE) begin
      sample_cnt_r <= sample_cnt_r - 5'h01;
    end
  end

  // Successive approximation: keep the trial bit when the input is above
  // the DAC, then try the next lower bit.
  always_comb begin
    trial_nxt = trial_r;
    if (!I_CMP_HIGH) begin
      trial_nxt[bit_r] = 1'b0;
    end
    if (bit_r != 4'h0) begin
      trial_nxt[bit_r - 4'h1] = 1'b1;
    end
  end

  // One tick per approximation bit, the guard bit included, so both
  // output widths take the same number of ticks.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      trial_r <= '0;
      bit_r   <= 4'h0;
    end else if (state_nxt == ACC_CONVERT && state_r != ACC_CONVERT) begin
      trial_r <= {1'b1, {(SAR_W-1){1'b0}}};
      bit_r   <= 4'(SAR_W - 1);
    end else if (tick && state_r == ACC_CONVERT) begin
      trial_r <= trial_nxt;
      if (bit_r != 4'h0) begin
        bit_r <= bit_r - 4'h1;
      end
    end
  end

  // The extra approximation bit lets both widths round to nearest;
  // a full-scale code saturates instead of wrapping to zero.
  assign round10 = {1'b0, trial_r} + {{SAR_W{1'b0}}, 1'b1};
  assign round8  = {1'b0, trial_r} + 12'h004;
  assign res10 = round10[SAR_W] ? {RESULT_W{1'b1}}
                                : round10[SAR_W-1:1];
  assign res8  = round8[SAR_W] ? 8'hff : round8[SAR_W-1:3];

  // An abort leaves both result bytes untouched; only a transfer
  // overwrites them.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      result_high_r <= 2'h0;
      result_low_r  <= 8'h00;
    end else if (transfer) begin
      if (mode_r == MODE_10BIT) begin
        result_high_r <= res10[RESULT_W-1:8];
        result_low_r  <= res10[7:0];
      end else begin
        result_high_r <= 2'h0;
        result_low_r  <= res8;
      end
    end
  end

  // The flag rises with the transfer; a clearing write in the same cycle
  // loses so that a finished result is never missed.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      complete_r <= 1'b0;
    end else if (transfer) begin
      complete_r <= 1'b1;
    end else if (wr_sc) begin
      complete_r <= 1'b0;
    end
  end

  // The transfer term lets the request follow the flag without waiting
  // an extra cycle for the flag register.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= (complete_r || transfer) && irq_en_r;
    end
  end

  // A status write latches the channel even when it is the all-ones
  // code that leaves the converter idle.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      channel_r    <= CHANNEL_RESET[CHANNEL_W-1:0];
      irq_en_r     <= 1'b0;
      continuous_r <= 1'b0;
    end else if (wr_sc) begin
      channel_r    <= I_WDATA[CHANNEL_W-1:0];
      irq_en_r     <= I_WDATA[SC_IRQ_EN_BIT];
      continuous_r <= I_WDATA[SC_CONTINUOUS_BIT];
    end
  end

  // Mode codes other than the ten-bit one fall back to eight-bit results.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      low_power_r   <= CLK_CFG_RESET[CC_LOW_POWER_BIT];
      div_sel_r     <= CLK_CFG_RESET[CC_DIV_HI:CC_DIV_LO];
      long_sample_r <= CLK_CFG_RESET[CC_LONG_SAMPLE_BIT];
      mode_r        <= CLK_CFG_RESET[CC_MODE_HI:CC_MODE_LO];
      async_sel_r   <= CLK_CFG_RESET[CC_ASYNC_BIT];
      bus_clk_sel_r <= CLK_CFG_RESET[CC_BUS_CLK_BIT];
    end else if (wr_cc) begin
      low_power_r   <= I_WDATA[CC_LOW_POWER_BIT];
      div_sel_r     <= I_WDATA[CC_DIV_HI:CC_DIV_LO];
      long_sample_r <= I_WDATA[CC_LONG_SAMPLE_BIT];
      mode_r        <= I_WDATA[CC_MODE_HI:CC_MODE_LO];
      async_sel_r   <= I_WDATA[CC_ASYNC_BIT];
      bus_clk_sel_r <= I_WDATA[CC_BUS_CLK_BIT];
    end
  end

  // Read data stand for one cycle after the strobe and are zero
  // otherwise, so a stale byte is never taken for a fresh one.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      unique case (I_ADDR)
        STATUS_CONTROL_REG: O_RDATA <= {complete_r, irq_en_r, continuous_r,
                                        channel_r};
        RESULT_HIGH_REG:    O_RDATA <= {6'h00, result_high_r};
        RESULT_LOW_REG:     O_RDATA <= result_low_r;
        CLOCK_CONFIG_REG:   O_RDATA <= {low_power_r, div_sel_r,
                                        long_sample_r, mode_r,
                                        async_sel_r, bus_clk_sel_r};
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // Analog side controls, all registered.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ASYNC_CLK_EN <= 1'b0;
      O_LOW_POWER    <= 1'b0;
      O_CHANNEL      <= CHANNEL_RESET[CHANNEL_W-1:0];
      O_CHANNEL_EN   <= 1'b0;
      O_SAMPLE       <= 1'b0;
      O_CONV_POWER   <= 1'b0;
      O_DAC_CODE     <= '0;
    end else begin
      // Async source runs only while busy with it selected; stop does
      // not gate it.
      O_ASYNC_CLK_EN <= (state_nxt != ACC_IDLE) && async_sel_r;
      O_LOW_POWER    <= low_power_r;
      O_CHANNEL      <= wr_sc ? I_WDATA[CHANNEL_W-1:0] : channel_r;
      O_CHANNEL_EN   <= (state_nxt != ACC_IDLE);
      O_SAMPLE       <= (state_nxt == ACC_SAMPLE);
      O_CONV_POWER   <= (state_nxt != ACC_IDLE);
      // The trial code leaves together with the state, so the comparator
      // has settled on it by the following tick.
      O_DAC_CODE     <= (tick && state_r == ACC_CONVERT) ? trial_nxt
                      : (state_nxt == ACC_CONVERT && state_r != ACC_CONVERT)
                      ? {1'b1, {(SAR_W-1){1'b0}}} : trial_r;
    end
  end
endmodule : acc_top
`default_nettype wire

//--- tb/acc_afe_model.sv
`default_nettype none
module acc_afe_model (
  input  wire logic        i_clk,
  input  wire logic [4:0]  i_channel,
  input  wire logic        i_channel_en,
  input  wire logic [10:0] i_dac_code,
  output logic             o_cmp_high
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] lvl [32];
  logic        junk = 1'b0;
  always @(posedge i_clk) junk <= ~junk;
  // Input sits half a step above lvl, so a trial equal to lvl reads above
  // and the approximation settles on lvl itself.
  // A disconnected mux gives the comparator nothing stable to report.
  assign o_cmp_high = i_channel_en ? (lvl[i_channel] >= i_dac_code)
                                   : junk;
endmodule : acc_afe_model
`default_nettype wire

//--- tb/acc_chk.sv
`default_nettype none
module acc_chk import acc_pkg::*; (
  input wire logic       I_SYS_CLK,
  input wire logic       I_RST_N,
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic       I_WR,
  input wire logic       O_IRQ,
  input wire logic       O_ASYNC_CLK_EN,
  input wire logic [4:0] O_CHANNEL,
  input wire logic       O_SAMPLE,
  input wire logic       O_CONV_POWER
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg_r;
  logic       ie_r;
  logic       cont_r;
  logic       wr0;
  logic       bus1;
  assign wr0 = I_WR && I_ADDR == STATUS_CONTROL_REG;
  // Exact cycle counts only hold for the undivided bus clock, short sample.
  assign bus1 = cfg_r[0] && !cfg_r[1] && cfg_r[6:4] == 3'h0;
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_r <= 8'h00;
      ie_r <= 1'b0;
      cont_r <= 1'b0;
    end else if (I_WR && I_ADDR == CLOCK_CONFIG_REG) begin
      cfg_r <= I_WDATA;
    end else if (wr0) begin
      ie_r <= I_WDATA[6];
      cont_r <= I_WDATA[5];
    end
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_sample;
    O_SAMPLE [*4] ##1 !O_SAMPLE;
  endsequence
  sequence s_single_tail;
    O_CONV_POWER [*8] ##[1:6] !O_CONV_POWER;
  endsequence
  a_irq_needs_en: assert property (O_IRQ |-> $past(ie_r))
    else $error("irq raised while disabled");
  a_off_no_start: assert property (
    wr0 && I_WDATA[4:0] == CHANNEL_OFF |=> !O_CONV_POWER)
    else $error("conversion ran with channel off");
  a_write_starts: assert property (
    wr0 && I_WDATA[4:0] != CHANNEL_OFF
    |=> O_SAMPLE && O_CHANNEL == $past(I_WDATA[4:0]))
    else $error("write did not start sampling");
  a_cfg_aborts: assert property (
    I_WR && I_ADDR == CLOCK_CONFIG_REG |=> !O_CONV_POWER)
    else $error("config write did not abort");
  a_async_select: assert property (O_ASYNC_CLK_EN |-> $past(cfg_r[1]))
    else $error("async clock enabled while not selected");
  a_sample_len: assert property ($rose(O_SAMPLE) && bus1 |-> s_sample)
    else $error("sample window length wrong");
  a_single_down: assert property (
    $fell(O_SAMPLE) && bus1 && !cont_r |-> s_single_tail)
    else $error("single conversion did not power down");
  a_cont_restart: assert property (
    $fell(O_SAMPLE) && bus1 && cont_r |-> ##[8:16] $rose(O_SAMPLE))
    else $error("continuous mode did not restart");
endmodule : acc_chk
bind acc_top acc_chk u_chk (.I_SYS_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR,
  .O_IRQ, .O_ASYNC_CLK_EN, .O_CHANNEL, .O_SAMPLE, .O_CONV_POWER);
`default_nettype wire

//--- tb/acc_top_bench.sv
`default_nettype none
module acc_top_bench import acc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        a_clk = 1'b0;
  logic        o_clk = 1'b0;
  logic        stop = 1'b0;
  logic        cmp, irq, a_en, low_pwr, chan_en, sample, power;
  logic [7:0]  rdata;
  logic [4:0]  chan;
  logic [10:0] dac;
  logic [31:0] seed = 32'h48e4befb;
  logic [7:0]  last_lo = 8'h00;
  int          n_errors = 0;
  int          cmp_count = 0;
  initial forever #10 clk = ~clk;
  // Offset so the oscillator never toggles on a bus clock edge.
  initial begin
    #5;
    forever #30 o_clk = ~o_clk;
  end
  // The async source stands still unless the block asks for it.
  initial forever begin
    #40;
    a_clk = a_en ? ~a_clk : 1'b0;
  end
  acc_top uut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .O_IRQ(irq),
    .I_ASYNC_CLK(a_clk), .I_OSC_OUT_CLK(o_clk), .I_STOP(stop),
    .O_ASYNC_CLK_EN(a_en), .O_LOW_POWER(low_pwr), .I_CMP_HIGH(cmp),
    .O_CHANNEL(chan), .O_CHANNEL_EN(chan_en), .O_SAMPLE(sample),
    .O_CONV_POWER(power), .O_DAC_CODE(dac));
  acc_afe_model afe (.i_clk(clk), .i_channel(chan), .i_channel_en(chan_en),
    .i_dac_code(dac), .o_cmp_high(cmp));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [9:0] exp_res(input logic [10:0] v,
                                         input logic ten);
    if (ten) return (v == 11'h7ff) ? 10'h3ff : 10'((12'(v) + 12'h001) >> 1);
    return (v > 11'h7fb) ? 10'h0ff : 10'((12'(v) + 12'h004) >> 3);
  endfunction : exp_res
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic conv(input logic [7:0] cfg, input logic [4:0] ch,
                      input logic [10:0] v, input logic ie);
    logic [9:0] e;
    logic [7:0] d;
    logic       ten;
    int         k;
    ten = cfg[3:2] == MODE_10BIT;
    afe.lvl[ch] = v;
    e = exp_res(v, ten);
    wr(CLOCK_CONFIG_REG, cfg);
    wr(STATUS_CONTROL_REG, {1'b0, ie, 1'b0, ch});
    @(posedge clk);
    #1;
    chk("async en", a_en, cfg[1]);
    chk("channel en", chan_en, 1'b1);
    d = 8'h00;
    for (k = 0; k < 3000 && d[7] !== 1'b1; k++) rd(STATUS_CONTROL_REG, d);
    chk("complete", d[7], 1'b1);
    chk("irq", irq, ie);
    rd(RESULT_LOW_REG, d);
    chk("result low", d, e[7:0]);
    rd(RESULT_HIGH_REG, d);
    chk("result high", d, {6'h00, ten ? e[9:8] : 2'h0});
    chk("power down", power, 1'b0);
    chk("low power", low_pwr, cfg[7]);
    last_lo = e[7:0];
  endtask : conv
  initial begin
    #1_900_000;
    n_errors++;
    give_verdict();
  end
  initial begin
    logic [31:0] r;
    logic [7:0]  d;
    logic [9:0]  e;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(STATUS_CONTROL_REG, d);
    chk("reset status", d, 8'h1f);
    rd(CLOCK_CONFIG_REG, d);
    chk("reset config", d, CLK_CFG_RESET);
    chk("reset channel", chan, 5'h1f);
    $display("test reset done");
    conv(8'h05, 5'h03, 11'h7ff, 1'b1);
    conv(8'h01, 5'h00, 11'h004, 1'b0);
    conv(8'h05, 5'h1e, 11'h002, 1'b1);
    for (int i = 0; i < 10; i++) begin
      r = xs();
      stop <= r[1] & r[13];
      conv(r[7:0], (r[12:8] == 5'h1f) ? 5'h00 : r[12:8],
           r[26:16], r[14]);
      stop <= 1'b0;
    end
    $display("test conversions done");
    wr(CLOCK_CONFIG_REG, 8'h64);
    wr(STATUS_CONTROL_REG, 8'h02);
    repeat (40) @(posedge clk);
    wr(STATUS_CONTROL_REG, 8'h1f);
    #1;
    chk("abort power", power, 1'b0);
    repeat (600) @(posedge clk);
    rd(STATUS_CONTROL_REG, d);
    chk("abort status", d, 8'h1f);
    rd(RESULT_LOW_REG, d);
    chk("abort keeps result", d, last_lo);
    stop <= 1'b1;
    wr(STATUS_CONTROL_REG, 8'h03);
    @(posedge clk);
    #1;
    chk("stop power", power, 1'b0);
    stop <= 1'b0;
    $display("test abort done");
    afe.lvl[4] = 11'h155;
    wr(CLOCK_CONFIG_REG, 8'h05);
    wr(STATUS_CONTROL_REG, 8'h24);
    repeat (30) @(posedge clk);
    afe.lvl[4] = 11'h6aa;
    e = exp_res(11'h6aa, 1'b1);
    repeat (40) @(posedge clk);
    rd(RESULT_LOW_REG, d);
    chk("continuous result", d, e[7:0]);
    chk("continuous power", power, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(STATUS_CONTROL_REG, d);
    chk("second reset", d, 8'h1f);
    $display("test continuous done");
    give_verdict();
  end
endmodule : acc_top_bench
`default_nettype wire
